// file: hw/standby_release_pkg.sv
// Constants and types for the standby release configuration block
// Operation
// - External interrupts 0..B and key-wakeup inputs 0..7 may release deep stop, sleep and idle modes.
// - The real-time-clock and two-phase counter interrupts may release sleep mode only.
// - The first configuration register holds sources 0..3, one per byte, enable in bit 0, selector in bits 5:4.
// - Selector 00 is low level, 01 high level, 10 falling edge, 11 rising edge.
// - A source raises a release request only while its enable bit is 1.
// - After reset all enables are 0 and all selectors are 10.
// - The second configuration register holds sources 4..7 with the same layout and reset values.
package standby_release_pkg;
  localparam logic [31:0] CFG_A_ADDR     = 32'hFFFFEE10;
  localparam logic [31:0] CFG_B_ADDR     = 32'hFFFFEE14;
  localparam logic [31:0] CFG_C_ADDR     = 32'hFFFFEE18;
  localparam logic [31:0] STATUS_ADDR    = 32'hFFFFEE1C;
  localparam logic [31:0] MASK_ADDR      = 32'hFFFFEE20;
  localparam int          EN_BIT         = 0;
  localparam int          SEL_LO         = 4;
  localparam logic [7:0]  LANE_MASK      = 8'h31;
  localparam logic [7:0]  LANE_RESET     = 8'h20;
  localparam int          NUM_CFG        = 12;
  localparam int          NUM_SRC        = 22;
  localparam logic [21:0] SRC_RESET      = 22'h000000;
  localparam logic [1:0]  SEL_LOW        = 2'h0;
  localparam logic [1:0]  SEL_HIGH       = 2'h1;
  localparam logic [1:0]  SEL_FALL       = 2'h2;
  localparam logic [1:0]  SEL_RISE       = 2'h3;
  localparam logic [2:0]  MODE_STOP      = 3'h1;
  localparam logic [2:0]  MODE_SLEEP     = 3'h2;
  localparam logic [2:0]  MODE_IDLE      = 3'h4;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage : standby_release_pkg

// file: hw/release_cfg_if.sv
// Interface carrying per-source enable and selector settings
`timescale 1ns/1ps
`default_nettype none
interface release_cfg_if;
  logic [11:0] enable;
  logic [23:0] select;
  modport regs (output enable, output select);
  modport detect (input enable, input select);
endinterface : release_cfg_if
`default_nettype wire

// file: hw/release_detect.sv
// Per-source active-state detector for configured release sources
`timescale 1ns/1ps
`default_nettype none
module release_detect
  import standby_release_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          arst_n,
  input  wire logic          ce,
  // Configuration
  release_cfg_if.detect      cfg,
  // Sources and result
  input  wire logic [11:0]   src_in,
  output logic      [11:0]   hit
);
  logic [11:0] prev;
  logic [11:0] next_prev;

  function automatic logic active(input logic [1:0] sel, input logic now, input logic old);
    case (sel)
      SEL_LOW:  active = !now;
      SEL_HIGH: active = now;
      SEL_FALL: active = old && !now;
      default:  active = !old && now;
    endcase
  endfunction : active

  always_comb
  begin
    next_prev = ce ? src_in : prev;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prev <= 12'h000;
    else
      prev <= next_prev;
  end

  genvar i;
  generate
    for (i = 0; i < 12; i++)
    begin : g_src
      // Edge selectors compare against last sampled level
      assign hit[i] = cfg.enable[i] && active(cfg.select[2*i +: 2], src_in[i], prev[i]);
    end
  endgenerate
endmodule : release_detect
`default_nettype wire

// file: hw/standby_release_top.sv
// Standby release configuration registers, detection and request outputs
`timescale 1ns/1ps
`default_nettype none
module standby_release_top
  import standby_release_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Release sources
  input  wire logic [11:0] ext_int,
  input  wire logic [7:0]  key_wakeup_input,
  input  wire logic        rtc_interrupt,
  input  wire logic        two_phase_counter_interrupt,
  // Standby state and results
  input  wire logic [2:0]  standby_mode,
  output logic             release_req,
  output logic             irq
);
  release_cfg_if cfg_bus ();

  logic [7:0]  lane [NUM_CFG];
  logic [7:0]  next_lane [NUM_CFG];
  logic [21:0] src_en;
  logic [21:0] next_src_en;
  logic [21:0] status;
  logic [21:0] next_status;
  logic [21:0] mask;
  logic [21:0] next_mask;
  bus_state_t  state;
  bus_state_t  next_state;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        next_release_req;
  logic        next_irq;
  logic [11:0] hit;
  logic [21:0] event_vec;
  logic        stop_or_idle;
  logic        sleep_mode;

  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++)
    begin : g_cfg
      assign cfg_bus.enable[g]         = lane[g][EN_BIT];
      assign cfg_bus.select[2*g +: 2]  = lane[g][SEL_LO +: 2];
    end
  endgenerate

  release_detect u_detect (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .cfg     (cfg_bus),
    .src_in  (ext_int),
    .hit     (hit)
  );

  assign event_vec = {two_phase_counter_interrupt, rtc_interrupt, key_wakeup_input, hit};
  assign stop_or_idle = (standby_mode == MODE_STOP) || (standby_mode == MODE_IDLE);
  assign sleep_mode   = (standby_mode == MODE_SLEEP);

  // Address decode for one register index
  function automatic logic [3:0] decode(input logic [31:0] a);
    if (a == CFG_A_ADDR)
      decode = 4'h1;
    else if (a == CFG_B_ADDR)
      decode = 4'h2;
    else if (a == CFG_C_ADDR)
      decode = 4'h3;
    else if (a == STATUS_ADDR)
      decode = 4'h4;
    else if (a == MASK_ADDR)
      decode = 4'h5;
    else
      decode = 4'h0;
  endfunction : decode

  always_comb
  begin
    logic [3:0] sel;
    logic [21:0] ev;
    sel              = decode(address);
    ev               = 22'h000000;
    next_lane        = lane;
    next_src_en      = src_en;
    next_mask        = mask;
    next_state       = state;
    next_readdata    = readdata;
    next_waitrequest = waitrequest;
    // Key and peripheral sources only need an enable bit
    ev[11:0]         = hit;
    ev[21:12]        = event_vec[21:12] & src_en[21:12];
    next_status      = status | ev;
    case (state)
      BUS_IDLE:
      begin
        if (read || write)
        begin
          next_state = BUS_ACK;
          next_readdata = 32'h00000000;
          if (read && sel >= 4'h1 && sel <= 4'h3)
          begin
            for (int b = 0; b < 4; b++)
              next_readdata[8*b +: 8] = lane[(sel - 4'h1) * 4 + b] & LANE_MASK;
          end
          else if (read && sel == 4'h4)
          begin
            next_readdata = {10'h000, status};
            // Read clears, but a same-cycle event survives
            next_status = ev;
          end
          else if (read && sel == 4'h5)
            next_readdata = {10'h000, mask};
          next_waitrequest = 1'b0;
        end
      end
      BUS_ACK:
      begin
        next_waitrequest = 1'b1;
        next_state = BUS_DONE;
        // Writes commit only on the edge the master sees waitrequest low
        if (write && sel >= 4'h1 && sel <= 4'h3)
        begin
          for (int b = 0; b < 4; b++)
            if (byteenable[b])
              next_lane[(sel - 4'h1) * 4 + b] = writedata[8*b +: 8] & LANE_MASK;
        end
        else if (write && sel == 4'h5)
          next_mask = writedata[21:0];
        else if (write && sel == 4'h4)
          next_src_en = writedata[21:0];
      end
      default:
        next_state = BUS_IDLE;
    endcase
    // Stop and idle accept only external and key sources
    next_release_req = (stop_or_idle && |status[19:0]) || (sleep_mode && |status);
    next_irq         = |(status & mask);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        lane[i] <= LANE_RESET;
      src_en      <= SRC_RESET;
      status      <= SRC_RESET;
      mask        <= SRC_RESET;
      state       <= BUS_IDLE;
      readdata    <= 32'h00000000;
      waitrequest <= 1'b1;
      release_req <= 1'b0;
      irq         <= 1'b0;
    end
    else if (ce)
    begin
      lane        <= next_lane;
      src_en      <= next_src_en;
      status      <= next_status;
      mask        <= next_mask;
      state       <= next_state;
      readdata    <= next_readdata;
      waitrequest <= next_waitrequest;
      release_req <= next_release_req;
      irq         <= next_irq;
    end
  end
endmodule : standby_release_top
`default_nettype wire

// file: bench/src_model.sv
// Source line model driving the release inputs
`timescale 1ns/1ps
`default_nettype none
module src_model (
  // Clock and lines
  input  wire logic        clk_sys,
  output logic      [21:0] src
);
  logic [21:0] lvl = 22'h000001;
  assign src = lvl;
  task automatic set(input int i, input logic v);
    @(posedge clk_sys);
    lvl[i] <= v;
  endtask : set
endmodule : src_model
`default_nettype wire

// file: bench/standby_release_checker.sv
// Port assertions for the standby release block
`timescale 1ns/1ps
`default_nettype none
module standby_release_checker
  import standby_release_pkg::*;
(
  // Watched ports
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [31:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        release_req
);
  logic wr_seen;
  logic next_wr_seen;
  always_comb next_wr_seen = wr_seen | (write & ~waitrequest);
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) wr_seen <= 1'b0;
    else wr_seen <= next_wr_seen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_new_req;
    $rose(read || write);
  endsequence
  sequence s_rd_ack(logic [31:0] a);
    read && !waitrequest && address == a;
  endsequence
  ack_pulse_a: assert property (!waitrequest |=> waitrequest) else $error("ack too long");
  ack_cause_a: assert property (!waitrequest |-> read || write) else $error("ack without request");
  ack_delay_a: assert property (s_new_req |=> !waitrequest) else $error("ack late");
  lane_a_zero_a: assert property (s_rd_ack(CFG_A_ADDR) |-> (readdata & 32'hCECECECE) == 32'h0)
    else $error("cfg_a spare bits set");
  lane_b_zero_a: assert property (s_rd_ack(CFG_B_ADDR) |-> (readdata & 32'hCECECECE) == 32'h0)
    else $error("cfg_b spare bits set");
  hole_zero_a: assert property (read && !waitrequest && address > MASK_ADDR |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!(read || write) |-> $stable(readdata)) else $error("readdata moved");
  idle_quiet_a: assert property (!wr_seen |-> !release_req) else $error("release while disabled");
endmodule : standby_release_checker
bind standby_release_top standby_release_checker u_standby_release_checker (.clk_sys, .arst_n, .address,
  .read, .write, .readdata, .waitrequest, .release_req);
`default_nettype wire

// file: bench/tb_standby_release_interrupt_config.sv
// Self-checking bench for the standby release block
`timescale 1ns/1ps
`default_nettype none
module tb_standby_release_interrupt_config
  import standby_release_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] address = 32'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic        waitrequest, release_req, irq;
  logic [2:0]  standby_mode = 3'h0;
  logic [21:0] src;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #50 clk_sys = ~clk_sys;
  // Whole run is about 150 cycles
  always @(posedge clk_sys)
    if (++cyc > 5000)
    begin
      failures++;
      wrap_up;
    end
  standby_release_top u_standby_release_top (.clk_sys, .arst_n, .ce(1'b1), .address, .read, .write,
    .byteenable(4'hF), .writedata, .readdata, .waitrequest, .ext_int(src[11:0]),
    .key_wakeup_input(src[19:12]), .rtc_interrupt(src[20]), .two_phase_counter_interrupt(src[21]),
    .standby_mode, .release_req, .irq);
  src_model u_src_model (.clk_sys, .src);
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Extra edge at the end keeps the dead cycle between accesses
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wait_req(input logic e, input string n);
    repeat (3) @(posedge clk_sys);
    check(n, {31'h0, release_req}, {31'h0, e});
  endtask : wait_req
  task automatic t_reset;
    bus(1'b0, CFG_A_ADDR, 32'h0);
    check("cfg_a", rd, 32'h20202020);
    bus(1'b0, CFG_B_ADDR, 32'h0);
    check("cfg_b", rd, 32'h20202020);
    bus(1'b0, 32'hFFFFEE40, 32'h0);
    check("hole", rd, 32'h0);
  endtask : t_reset
  task automatic t_unused;
    bus(1'b1, CFG_B_ADDR, 32'hFFFFFFFF);
    bus(1'b0, CFG_B_ADDR, 32'h0);
    check("cfg_b", rd, 32'h31313131);
  endtask : t_unused
  // Active level of each selector equals its low bit
  task automatic t_select;
    standby_mode <= MODE_STOP;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, CFG_A_ADDR, {26'h0, k[1:0], 4'h1});
      bus(1'b0, STATUS_ADDR, 32'h0);
      wait_req(1'b0, "inactive");
      u_src_model.set(0, k[0]);
      wait_req(1'b1, "active");
    end
  endtask : t_select
  task automatic t_disable;
    bus(1'b1, CFG_A_ADDR, 32'h30);
    u_src_model.set(0, 1'b0);
    bus(1'b0, STATUS_ADDR, 32'h0);
    u_src_model.set(0, 1'b1);
    wait_req(1'b0, "disabled");
  endtask : t_disable
  task automatic t_sleep_only;
    bus(1'b1, STATUS_ADDR, 32'h00100100);
    u_src_model.set(20, 1'b1);
    wait_req(1'b0, "stop");
    standby_mode <= MODE_SLEEP;
    wait_req(1'b1, "sleep");
  endtask : t_sleep_only
  task automatic t_irq;
    bus(1'b1, MASK_ADDR, 32'h00100000);
    // Mask lands on the ack edge, irq one edge later
    @(posedge clk_sys);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, MASK_ADDR, 32'h0);
    @(posedge clk_sys);
    check("masked", {31'h0, irq}, 32'h0);
    u_src_model.set(20, 1'b0);
    bus(1'b1, MASK_ADDR, 32'h00100000);
    bus(1'b0, STATUS_ADDR, 32'h0);
    check("status", rd & 32'h00100000, 32'h00100000);
    bus(1'b0, MASK_ADDR, 32'h0);
    check("cleared", {31'h0, irq}, 32'h0);
  endtask : t_irq
  // Idle mode takes key wakeups but not the counter interrupt
  task automatic t_idle_key;
    standby_mode <= MODE_IDLE;
    bus(1'b1, STATUS_ADDR, 32'h00201000);
    bus(1'b0, STATUS_ADDR, 32'h0);
    u_src_model.set(21, 1'b1);
    wait_req(1'b0, "idle counter");
    u_src_model.set(12, 1'b1);
    wait_req(1'b1, "idle key");
  endtask : t_idle_key
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    t_unused;
    t_select;
    t_disable;
    t_sleep_only;
    t_irq;
    t_idle_key;
    wrap_up;
  end
endmodule : tb_standby_release_interrupt_config
`default_nettype wire
